/* File: core/pcsr_regs.v */
`timescale 1ns/1ns
`include "pcsr_defines.vh"
// ============================================================
// Configuration and live status registers behind management port
// ============================================================
module pcsr_regs
#(
    parameter SLEEP_T0_CYCLES = 32'd304000000, // Code 00 idle cycles
    parameter SLEEP_T1_CYCLES = 32'd200000000, // Code 01 idle cycles
    parameter SLEEP_T2_CYCLES = 32'd104000000 // Code 10 idle cycles
)
(
    input wire clk, // Core clock, 100 MHz
    input wire reset_n, // Async reset, active low
    input wire mdc, // Management clock pin
    input wire mdio_in, // Management data pin, input
    output reg mdio_out, // Management data pin, output
    output reg mdio_oe, // Management data pin, drive enable
    input wire [4:0] phy_address, // Address strap pins
    input wire sleep_strap, // Sleep default strap pin
    input wire media_select_strap, // Fiber default strap pin
    input wire speed_100, // Operating in 100BASE-TX
    input wire tx_active, // Transmitting a packet
    input wire rx_active, // Receiving a packet
    input wire collision, // Collision occurring
    input wire link_up, // Link is up
    input wire full_duplex, // Full duplex operation
    input wire autoneg_mode, // Auto-negotiation mode
    input wire autoneg_complete, // Negotiation completion bit
    input wire polarity_reversed, // Receive polarity reversed
    input wire pause_capable, // Device pause capable
    input wire error_seen, // Error condition occurred
    input wire link_integrity_ok, // Normal link detection result
    input wire line_idle, // No line activity
    input wire page_received_event, // New page received pulse
    input wire mr_page_rx, // Negotiation page-received variable
    input wire page_reg_read, // Page flag register read pulse
    output reg link_pass, // Link treated as passing
    output reg tp_tx_disable, // Line transmitter off
    output reg scrambler_bypass, // Bypass scrambler and descrambler
    output reg jabber_disable, // Jabber correction off
    output reg heartbeat_run, // Heartbeat function active
    output reg tp_loopback_enable, // Half-duplex loopback active
    output reg crs_extend, // Hold CRS until RX_DV falls
    output reg sleep_enable, // Sleep mode allowed
    output reg rx_dv_on_crs, // RX_DV with CRS, preamble on RXD
    output reg fefi_enable, // Far-end fault transmission on
    output reg alt_next_page, // Alternate next-page feature on
    output reg fiber_mode, // Fiber media selected
    output wire sleep_request, // Idle long enough to sleep
    output reg page_received_flag // Latched page received
);
    // ========================================================
    // Frame states
    // ========================================================
    localparam ST_PRE = 2'h0; // Counting preamble ones
    localparam ST_HDR = 2'h1; // Start, opcode, addresses
    localparam ST_TA = 2'h2; // Turnaround
    localparam ST_DATA = 2'h3; // Sixteen data bits

    wire [8:0] pins_s; // Synchronised pins
    wire mdc_s; // Synchronised management clock
    wire mdio_s; // Synchronised management data
    wire [4:0] addr_s; // Synchronised address strap
    wire sleep_strap_s; // Synchronised sleep strap
    wire media_strap_s; // Synchronised media strap
    reg mdc_d; // Delayed clock for edge detect
    wire mdc_rise; // Management clock rising edge
    reg [1:0] state; // Frame state
    reg [5:0] ones; // Preamble ones counted
    reg [3:0] hcnt; // Header bit counter
    reg [4:0] dcnt; // Data bit counter
    reg [12:0] hdr; // Header bits so far
    reg [15:0] shreg; // Data shift register
    reg is_read; // Frame is a read
    reg ta_seen; // First turnaround bit passed
    reg [4:0] reg_addr; // Addressed register
    reg [15:0] cfg; // Configuration register
    reg [1:0] strap_cnt; // Cycles since reset release
    wire [13:0] hdr_full; // Complete header
    wire ten_t; // 10BASE-T operation
    wire page_clear; // Page flag clear condition

    // ========================================================
    // Pin synchronisation and edge detect
    // ========================================================
    pcsr_sync #(.WIDTH(9)) u_sync
    (
        .clk(clk),
        .reset_n(reset_n),
        .d({mdc, mdio_in, phy_address, sleep_strap, media_select_strap}),
        .q(pins_s)
    );

    assign mdc_s = pins_s[8];
    assign mdio_s = pins_s[7];
    assign addr_s = pins_s[6:2];
    assign sleep_strap_s = pins_s[1];
    assign media_strap_s = pins_s[0];
    assign mdc_rise = mdc_s & ~mdc_d;
    assign hdr_full = {hdr, mdio_s};

    // Previous synchronised clock level
    always @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            mdc_d <= 1'b0;
        else
            mdc_d <= mdc_s;
    end

    // ========================================================
    // Live status assembly, reserved bits zero
    // ========================================================
    function [15:0] status_word;
        input dummy; // Unused, keeps function legal
        begin
            status_word = 16'h0000;
            status_word[`PCSR_ST_SPEED_100] = speed_100;
            status_word[`PCSR_ST_TX_ACTIVE] = tx_active;
            status_word[`PCSR_ST_RX_ACTIVE] = rx_active;
            status_word[`PCSR_ST_COLLISION] = collision;
            status_word[`PCSR_ST_LINK_UP] = link_up;
            status_word[`PCSR_ST_FULL_DUPLEX] = full_duplex;
            status_word[`PCSR_ST_AUTONEG] = autoneg_mode;
            status_word[`PCSR_ST_AN_DONE] = autoneg_complete;
            status_word[`PCSR_ST_POLARITY] = polarity_reversed;
            status_word[`PCSR_ST_PAUSE] = pause_capable;
            status_word[`PCSR_ST_ERROR] = error_seen;
        end
    endfunction

    // Read data by register address
    function [15:0] read_word;
        input [4:0] addr; // Register address
        begin
            if (addr == `PCSR_REG_CONFIG)
                read_word = cfg;
            else if (addr == `PCSR_REG_STATUS)
                read_word = status_word(1'b0); // Sampled live
            else
                read_word = 16'h0000;
        end
    endfunction

    // ========================================================
    // Management frame engine
    // ========================================================
    // Data changes and samples on synchronised rising MDC edges
    always @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state <= ST_PRE;
            ones <= 6'h00;
            hcnt <= 4'h0;
            dcnt <= 5'h00;
            hdr <= 13'h0000;
            shreg <= 16'h0000;
            is_read <= 1'b0;
            ta_seen <= 1'b0;
            reg_addr <= 5'h00;
            mdio_out <= 1'b0;
            mdio_oe <= 1'b0;
        end
        else if (mdc_rise)
        begin
            case (state)
                ST_PRE:
                begin
                    // Look for enough ones, then the first start bit
                    if (mdio_s)
                    begin
                        if (ones != `PCSR_PREAMBLE_ONES)
                            ones <= ones + 6'h01;
                    end
                    else if (ones == `PCSR_PREAMBLE_ONES)
                    begin
                        state <= ST_HDR;
                        hdr <= 13'h0000;
                        hcnt <= 4'h1;
                        ones <= 6'h00;
                    end
                    else
                        ones <= 6'h00;
                end
                ST_HDR:
                begin
                    hdr <= hdr_full[12:0];
                    hcnt <= hcnt + 4'h1;
                    // Last header bit: check start, opcode, address
                    if (hcnt == `PCSR_HDR_BITS)
                    begin
                        reg_addr <= hdr_full[4:0];
                        ta_seen <= 1'b0;
                        if (hdr_full[13:12] != `PCSR_START_CODE ||
                            hdr_full[9:5] != addr_s)
                            state <= ST_PRE;
                        else if (hdr_full[11:10] == `PCSR_OP_READ)
                        begin
                            state <= ST_TA;
                            is_read <= 1'b1;
                            shreg <= read_word(hdr_full[4:0]);
                        end
                        else if (hdr_full[11:10] == `PCSR_OP_WRITE)
                        begin
                            state <= ST_TA;
                            is_read <= 1'b0;
                        end
                        else
                            state <= ST_PRE;
                    end
                end
                ST_TA:
                begin
                    dcnt <= 5'h00;
                    if (is_read)
                    begin
                        // Drive the second turnaround bit low
                        mdio_oe <= 1'b1;
                        mdio_out <= 1'b0;
                        state <= ST_DATA;
                    end
                    else if (ta_seen)
                        state <= ST_DATA;
                    else
                        ta_seen <= 1'b1;
                end
                ST_DATA:
                begin
                    if (is_read)
                    begin
                        // Shift out, release after last bit sampled
                        if (dcnt == `PCSR_DATA_BITS)
                        begin
                            mdio_oe <= 1'b0;
                            mdio_out <= 1'b0;
                            state <= ST_PRE;
                        end
                        else
                        begin
                            mdio_out <= shreg[15];
                            shreg <= {shreg[14:0], 1'b0};
                            dcnt <= dcnt + 5'h01;
                        end
                    end
                    else
                    begin
                        // Shift in write data
                        shreg <= {shreg[14:0], mdio_s};
                        dcnt <= dcnt + 5'h01;
                        if (dcnt == `PCSR_DATA_BITS - 5'h01)
                            state <= ST_PRE;
                    end
                end
                default:
                begin
                    state <= ST_PRE;
                    mdio_oe <= 1'b0;
                end
            endcase
        end
    end

    // ========================================================
    // Configuration register
    // ========================================================
    // Straps load after synchronisers settle; writes store all bits
    always @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            cfg <= `PCSR_CFG_RESET;
            strap_cnt <= 2'h0;
        end
        else
        begin
            if (strap_cnt != 2'h3)
                strap_cnt <= strap_cnt + 2'h1;
            if (strap_cnt == `PCSR_STRAP_LOAD)
            begin
                cfg[`PCSR_CFG_SLEEP_EN] <= sleep_strap_s;
                cfg[`PCSR_CFG_FIBER] <= media_strap_s;
            end
            else if (mdc_rise && state == ST_DATA && !is_read &&
                     dcnt == `PCSR_DATA_BITS - 5'h01 &&
                     reg_addr == `PCSR_REG_CONFIG)
                cfg <= {shreg[14:0], mdio_s};
        end
    end

    // ========================================================
    // Control outputs derived from configuration and mode
    // ========================================================
    assign ten_t = ~speed_100 & ~cfg[`PCSR_CFG_FIBER];

    // Registered controls steering the transceiver
    always @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            link_pass <= 1'b0;
            tp_tx_disable <= 1'b0;
            scrambler_bypass <= 1'b0;
            jabber_disable <= 1'b0;
            heartbeat_run <= 1'b0;
            tp_loopback_enable <= 1'b0;
            crs_extend <= 1'b0;
            sleep_enable <= 1'b0;
            rx_dv_on_crs <= 1'b0;
            fefi_enable <= 1'b0;
            alt_next_page <= 1'b0;
            fiber_mode <= 1'b0;
        end
        else
        begin
            link_pass <= cfg[`PCSR_CFG_FORCE_LINK] | link_integrity_ok;
            tp_tx_disable <= cfg[`PCSR_CFG_TX_DISABLE];
            scrambler_bypass <= cfg[`PCSR_CFG_BYPASS_SCR] & speed_100;
            jabber_disable <= cfg[`PCSR_CFG_JABBER_DIS] & ten_t;
            heartbeat_run <= cfg[`PCSR_CFG_HEARTBEAT] & ten_t;
            // Loopback only in 10BASE-T half duplex unless disabled
            tp_loopback_enable <= ten_t & ~full_duplex &
                                  ~cfg[`PCSR_CFG_LOOPBACK_DIS];
            crs_extend <= cfg[`PCSR_CFG_CRS_SELECT] & ten_t;
            sleep_enable <= cfg[`PCSR_CFG_SLEEP_EN];
            rx_dv_on_crs <= cfg[`PCSR_CFG_PREAMBLE_EN];
            fefi_enable <= cfg[`PCSR_CFG_FEFI_EN];
            alt_next_page <= cfg[`PCSR_CFG_ALT_NP];
            fiber_mode <= cfg[`PCSR_CFG_FIBER];
        end
    end

    // ========================================================
    // Sleep timer
    // ========================================================
    pcsr_idle_timer
    #(
        .T0_CYCLES(SLEEP_T0_CYCLES),
        .T1_CYCLES(SLEEP_T1_CYCLES),
        .T2_CYCLES(SLEEP_T2_CYCLES)
    )
    u_idle
    (
        .clk(clk),
        .reset_n(reset_n),
        .enable(cfg[`PCSR_CFG_SLEEP_EN]),
        .idle(line_idle),
        .sel(cfg[`PCSR_CFG_SLEEP_HI:`PCSR_CFG_SLEEP_LO]),
        .sleep_req(sleep_request)
    );

    // ========================================================
    // Latched page received flag
    // ========================================================
    // Alternate mode adds clears; a new page wins over any clear
    assign page_clear = page_reg_read |
                        (cfg[`PCSR_CFG_ALT_NP] &
                         (~mr_page_rx | cfg[`PCSR_CFG_TX_DISABLE]));

    always @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            page_received_flag <= 1'b0;
        else if (page_received_event)
            page_received_flag <= 1'b1;
        else if (page_clear)
            page_received_flag <= 1'b0;
    end
endmodule // pcsr_regs

/* File: shared/pcsr_defines.vh */
`ifndef PCSR_DEFINES_VH
`define PCSR_DEFINES_VH
// ============================================================
// Management frame and register map
// ============================================================
`define PCSR_REG_CONFIG 5'h10 // Configuration register address
`define PCSR_REG_STATUS 5'h11 // Live status register address
`define PCSR_PREAMBLE_ONES 6'h20 // Ones needed before a start
`define PCSR_START_CODE 2'h1 // Start of frame pattern
`define PCSR_OP_READ 2'h2 // Read opcode
`define PCSR_OP_WRITE 2'h1 // Write opcode
`define PCSR_HDR_BITS 4'hD // Header bit index of last bit
`define PCSR_DATA_BITS 5'h10 // Data bits per frame
// ============================================================
// Configuration register fields
// ============================================================
`define PCSR_CFG_FORCE_LINK 14 // Force link pass
`define PCSR_CFG_TX_DISABLE 13 // Disable line transmitter
`define PCSR_CFG_BYPASS_SCR 12 // Bypass scrambler and descrambler
`define PCSR_CFG_JABBER_DIS 10 // Disable jabber correction
`define PCSR_CFG_HEARTBEAT 9 // Heartbeat enable
`define PCSR_CFG_LOOPBACK_DIS 8 // Disable half-duplex loopback
`define PCSR_CFG_CRS_SELECT 7 // Carrier sense extension
`define PCSR_CFG_SLEEP_EN 6 // Sleep mode enable
`define PCSR_CFG_PREAMBLE_EN 5 // Receive preamble enable
`define PCSR_CFG_SLEEP_HI 4 // Sleep timer field, upper bit
`define PCSR_CFG_SLEEP_LO 3 // Sleep timer field, lower bit
`define PCSR_CFG_FEFI_EN 2 // Far-end fault enable
`define PCSR_CFG_ALT_NP 1 // Alternate next page feature
`define PCSR_CFG_FIBER 0 // Fiber select
`define PCSR_CFG_RESET 16'h0084 // Reset value before straps
// ============================================================
// Live status register fields
// ============================================================
`define PCSR_ST_SPEED_100 14 // 100BASE-TX mode
`define PCSR_ST_TX_ACTIVE 13 // Transmitting a packet
`define PCSR_ST_RX_ACTIVE 12 // Receiving a packet
`define PCSR_ST_COLLISION 11 // Collision occurring
`define PCSR_ST_LINK_UP 10 // Link up
`define PCSR_ST_FULL_DUPLEX 9 // Full duplex
`define PCSR_ST_AUTONEG 8 // Auto-negotiation mode
`define PCSR_ST_AN_DONE 7 // Auto-negotiation complete
`define PCSR_ST_POLARITY 5 // Polarity reversed
`define PCSR_ST_PAUSE 4 // Pause capable
`define PCSR_ST_ERROR 3 // Error occurred
// ============================================================
// Timing
// ============================================================
`define PCSR_CLK_KHZ 100000 // Core clock rate in kHz
`define PCSR_SLEEP_T0_MS 3040 // Sleep timer code 00, in ms
`define PCSR_SLEEP_T1_MS 2000 // Sleep timer code 01, in ms
`define PCSR_SLEEP_T2_MS 1040 // Sleep timer code 10, in ms
`define PCSR_STRAP_LOAD 2'h2 // Cycle after release straps load
`endif

/* File: core/pcsr_sync.v */
`timescale 1ns/1ns
// ============================================================
// Two-flop synchroniser for pin inputs
// ============================================================
module pcsr_sync
#(
    parameter WIDTH = 1 // Number of bits
)
(
    input wire clk, // Core clock
    input wire reset_n, // Async reset, active low
    input wire [WIDTH-1:0] d, // Asynchronous input
    output reg [WIDTH-1:0] q // Synchronised output
);
    reg [WIDTH-1:0] meta; // First stage, read only by q

    // Two stages, second is the only reader of the first
    always @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            meta <= {WIDTH{1'b0}};
            q <= {WIDTH{1'b0}};
        end
        else
        begin
            meta <= d;
            q <= meta;
        end
    end
endmodule // pcsr_sync

/* File: core/pcsr_idle_timer.v */
`timescale 1ns/1ns
// ============================================================
// Idle timer that requests sleep
// ============================================================
module pcsr_idle_timer
#(
    parameter T0_CYCLES = 32'd304000000, // Code 00 idle time
    parameter T1_CYCLES = 32'd200000000, // Code 01 idle time
    parameter T2_CYCLES = 32'd104000000 // Code 10 idle time
)
(
    input wire clk, // Core clock
    input wire reset_n, // Async reset, active low
    input wire enable, // Sleep allowed
    input wire idle, // Line is idle
    input wire [1:0] sel, // Sleep timer code
    output reg sleep_req // Idle long enough, sleep
);
    reg [31:0] count; // Idle cycles so far
    reg [31:0] limit; // Selected idle time

    // Code to cycle count; undefined code 11 takes the longest time
    always @*
    begin
        case (sel)
            2'h1: limit = T1_CYCLES;
            2'h2: limit = T2_CYCLES;
            default: limit = T0_CYCLES;
        endcase
    end

    // Count idle time, restart on activity or disable
    always @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            count <= 32'h00000000;
            sleep_req <= 1'b0;
        end
        else if (!enable || !idle)
        begin
            count <= 32'h00000000;
            sleep_req <= 1'b0;
        end
        else if (count + 32'h00000001 >= limit)
        begin
            sleep_req <= 1'b1;
        end
        else
        begin
            count <= count + 32'h00000001;
        end
    end
endmodule // pcsr_idle_timer

/* File: bench/pcsr_properties.sv */
`timescale 1ns/1ns
// ====================
// Control output checks
module pcsr_props
(
    input wire clk, // Clock
    input wire reset_n, // Reset
    input wire speed_100, // In
    input wire full_duplex, // In
    input wire link_integrity_ok, // In
    input wire page_received_event, // In
    input wire link_pass, // Out
    input wire scrambler_bypass, // Out
    input wire jabber_disable, // Out
    input wire heartbeat_run, // Out
    input wire tp_loopback_enable, // Out
    input wire crs_extend, // Out
    input wire fiber_mode, // Out
    input wire sleep_enable, // Out
    input wire sleep_request, // Out
    input wire page_received_flag // Out
);
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    property p_link; link_integrity_ok |=> link_pass; endproperty
    a_link: assert property (p_link) else $error("link pass");
    property p_byp; scrambler_bypass |-> $past(speed_100); endproperty
    a_byp: assert property (p_byp) else $error("bypass");
    property p_jab; jabber_disable |-> !fiber_mode && !$past(speed_100); endproperty
    a_jab: assert property (p_jab) else $error("jabber");
    property p_hb; heartbeat_run |-> !fiber_mode && !$past(speed_100); endproperty
    a_hb: assert property (p_hb) else $error("heartbeat");
    property p_loop; tp_loopback_enable |-> !$past(speed_100 || full_duplex); endproperty
    a_loop: assert property (p_loop) else $error("loopback");
    property p_crs; crs_extend |-> !fiber_mode && !$past(speed_100); endproperty
    a_crs: assert property (p_crs) else $error("crs extend");
    property p_sleep; sleep_request |-> sleep_enable; endproperty
    a_sleep: assert property (p_sleep) else $error("sleep");
    property p_page; page_received_event |=> page_received_flag; endproperty
    a_page: assert property (p_page) else $error("page flag");
endmodule // pcsr_props

/* File: bench/pcsr_mgmt_master.sv */
`timescale 1ns/1ns
// ====================
// Management master model
module pcsr_mgmt_master
#(
    parameter ADDR = 5'h01 // Device address
)
(
    input wire clk, // Core clock
    input wire mdio_out, // Device data
    input wire mdio_oe, // Device drive enable
    output reg mdc = 1'b0, // Management clock
    output wire mdio_in // Resolved line
);
    reg m_oe = 1'b0; // Master drives
    reg m_d = 1'b1; // Master data
    // Pull-up when nobody drives
    assign mdio_in = mdio_oe ? mdio_out : (m_oe ? m_d : 1'b1);
    // Half an MDC period
    task half;
        begin
            repeat (5) @(posedge clk);
            #1;
        end
    endtask
    // One frame; released at turnaround on reads
    task xfer(input [1:0] op, input [4:0] rg, input [15:0] wd, output [15:0] rd);
        reg [63:0] f;
        integer i;
        begin
            f = {32'hFFFFFFFF, 2'b01, op, ADDR, rg, 2'b10, wd};
            for (i = 63; i >= 0; i = i - 1)
            begin
                m_oe = (i > 17) || (op == 2'b01);
                m_d = f[i];
                half;
                if (i < 16)
                    rd[i] = mdio_in;
                mdc = 1'b1;
                half;
                mdc = 1'b0;
            end
            m_oe = 1'b0;
            half;
        end
    endtask
endmodule // pcsr_mgmt_master

/* File: bench/testbench.sv */
`timescale 1ns/1ns
// ====================
// Register bank bench
module testbench;
    reg clk = 1'b0, reset_n = 1'b0, sleep_strap = 1'b1, media_select_strap = 1'b0; // Pins
    reg link_integrity_ok = 1'b0, line_idle = 1'b0, mr_page_rx = 1'b1; // Line state
    reg page_received_event = 1'b0, page_reg_read = 1'b0; // Page pulses
    reg [10:0] st = 11'h000; // Status levels
    reg [15:0] rv; // Read value
    integer fail_count = 0, checked = 0, n, c; // Counters
    wire [4:0] phy_address = 5'h01; // Address strap
    wire speed_100 = st[10], tx_active = st[9], rx_active = st[8], collision = st[7];
    wire link_up = st[6], full_duplex = st[5], autoneg_mode = st[4], autoneg_complete = st[3];
    wire polarity_reversed = st[2], pause_capable = st[1], error_seen = st[0];
    wire mdc, mdio_in, mdio_out, mdio_oe, sleep_request, page_received_flag; // Pins
    wire link_pass, tp_tx_disable, scrambler_bypass, jabber_disable, heartbeat_run; // Controls
    wire tp_loopback_enable, crs_extend, sleep_enable, rx_dv_on_crs, fefi_enable; // Controls
    wire alt_next_page, fiber_mode; // Controls
    wire [11:0] ctl = {link_pass, tp_tx_disable, scrambler_bypass, jabber_disable,
        heartbeat_run, tp_loopback_enable, crs_extend, sleep_enable, rx_dv_on_crs,
        fefi_enable, alt_next_page, fiber_mode};
    pcsr_regs #(.SLEEP_T0_CYCLES(32'd40), .SLEEP_T1_CYCLES(32'd30), .SLEEP_T2_CYCLES(32'd20))
    pcsr_regs_inst (.clk, .reset_n, .mdc, .mdio_in, .mdio_out, .mdio_oe, .phy_address,
        .sleep_strap, .media_select_strap, .speed_100, .tx_active, .rx_active, .collision,
        .link_up, .full_duplex, .autoneg_mode, .autoneg_complete, .polarity_reversed,
        .pause_capable, .error_seen, .link_integrity_ok, .line_idle, .page_received_event,
        .mr_page_rx, .page_reg_read, .link_pass, .tp_tx_disable, .scrambler_bypass,
        .jabber_disable, .heartbeat_run, .tp_loopback_enable, .crs_extend, .sleep_enable,
        .rx_dv_on_crs, .fefi_enable, .alt_next_page, .fiber_mode, .sleep_request,
        .page_received_flag);
    pcsr_mgmt_master pcsr_mgmt_master_inst (.clk, .mdio_out, .mdio_oe, .mdc, .mdio_in);
    always #5 clk = ~clk; // 100 MHz
    // Wait k edges, then settle
    task tick(input integer k);
        begin
            repeat (k) @(posedge clk);
            #1;
        end
    endtask
    // Compare one value
    task chk(input [63:0] what, input [15:0] exp, input [15:0] got);
        begin
            checked = checked + 1;
            if (got !== exp)
            begin
                fail_count = fail_count + 1;
                $display("wrong value %0s exp %h got %h", what, exp, got);
            end
        end
    endtask
    // Register read with compare
    task rd(input [4:0] rg, input [15:0] exp);
        begin
            pcsr_mgmt_master_inst.xfer(2'b10, rg, 16'h0000, rv);
            chk("read", exp, rv);
        end
    endtask
    // Register write, then let controls settle
    task wr(input [4:0] rg, input [15:0] d);
        begin
            pcsr_mgmt_master_inst.xfer(2'b01, rg, d, rv);
            tick(2);
        end
    endtask
    // Page event pulse, then flag check
    task page(input [15:0] exp);
        begin
            page_received_event = 1'b1;
            tick(1);
            page_received_event = 1'b0;
            tick(2);
            chk("page", exp, {15'h0000, page_received_flag});
        end
    endtask
    // Verdict
    task report_and_stop;
        begin
            if (fail_count == 0 && checked > 0)
                $display("== PASSED ==");
            else
                $display("== FAILED ==");
            $finish;
        end
    endtask
    // Main sequence
    initial
    begin
        tick(3);
        reset_n = 1'b1;
        tick(6);
        rd(5'h10, 16'h00C4);
        wr(5'h10, 16'h77E6);
        rd(5'h10, 16'h77E6);
        chk("ctl", 16'h0DBE, {4'h0, ctl});
        page(16'h0000);
        link_integrity_ok = 1'b1;
        wr(5'h10, 16'h0000);
        chk("ctl", 16'h0840, {4'h0, ctl});
        page(16'h0001);
        page_reg_read = 1'b1;
        tick(1);
        page_reg_read = 1'b0;
        tick(1);
        chk("page", 16'h0000, {15'h0000, page_received_flag});
        for (c = 0; c < 3; c = c + 1)
        begin
            st = (c == 0) ? 11'h555 : ((c == 1) ? 11'h2AA : 11'h7FF);
            rd(5'h11, {1'b0, st[10:3], 1'b0, st[2:0], 3'h0});
        end
        wr(5'h10, 16'h1000);
        chk("ctl", 16'h0A00, {4'h0, ctl});
        rd(5'h12, 16'h0000);
        st = 11'h000;
        for (c = 0; c < 3; c = c + 1)
        begin
            line_idle = 1'b0;
            wr(5'h10, {9'h000, 1'b1, 1'b0, c[1:0], 3'h0});
            line_idle = 1'b1;
            n = 0;
            while (sleep_request !== 1'b1 && n < 60)
            begin
                tick(1);
                n = n + 1;
            end
            chk("sleep", 16'h0001, {15'h0000, n >= 38 - 10 * c && n <= 42 - 10 * c});
        end
        report_and_stop;
    end
endmodule // testbench
bind pcsr_regs pcsr_props pcsr_props_inst (.clk, .reset_n, .speed_100, .full_duplex,
    .link_integrity_ok, .page_received_event, .link_pass, .scrambler_bypass, .jabber_disable,
    .heartbeat_run, .tp_loopback_enable, .crs_extend, .fiber_mode, .sleep_enable,
    .sleep_request, .page_received_flag);
